/* hdl/calib_loss_flag.sv */
`timescale 1ns/100ps
module calib_loss_flag #(
    parameter int UNITS = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // events and software clear
    input wire logic [UNITS-1:0] loss_set,
    input wire logic [UNITS-1:0] loss_clr,
    // sticky state
    output logic [UNITS-1:0] calib_loss_flags
);
    logic [UNITS-1:0] flags_reg;
    logic [UNITS-1:0] flags_next;

    always_comb begin
        // set wins so an event in the clearing cycle survives
        flags_next = (flags_reg & ~loss_clr) | loss_set;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign calib_loss_flags = flags_reg;
endmodule

/* hdl/irq_mode_decode.sv */
`timescale 1ns/100ps
module irq_mode_decode (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // host interrupt setup
    input wire modstat_pkg::irq_cfg_t irq_cfg,
    // decoded mode
    output modstat_pkg::irq_mode_t irq_mode
);
    modstat_pkg::irq_mode_t mode_reg;
    modstat_pkg::irq_mode_t mode_next;

    always_comb begin
        mode_next.msi = irq_cfg.msi_enable;
        mode_next.legacy = !irq_cfg.msi_enable && !irq_cfg.intx_disable;
        // neither mechanism usable: nothing may be signalled
        mode_next.error = !irq_cfg.msi_enable && irq_cfg.intx_disable;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= '0;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign irq_mode = mode_reg;
endmodule

/* hdl/modstat_pkg.sv */
package modstat_pkg;
    // register placement inside the module register space
    localparam int ADDR_W = 9;
    localparam logic [8:0] MODULE_STATUS_OFS = 9'h004;
    localparam logic [31:0] MODULE_STATUS_RST = 32'h0000_0000;
    // field positions of the status word
    localparam int UNIT_COUNT = 4;
    localparam int LOSS_LSB = 16;
    localparam int LOSS_BYTE = 2;
    localparam int IMP_DONE_BIT = 12;
    localparam int REAR_BIT = 8;
    localparam int CAL_DONE_LSB = 4;
    localparam int MSI_BIT = 3;
    localparam int LEGACY_BIT = 2;
    localparam int ERR_BIT = 0;
    // timing of the impedance controller reset pulse
    localparam int CLK_PERIOD_NS = 40;
    localparam int IMP_RST_NS = 200;
    localparam int IMP_RST_CYCLES = (IMP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IMP_CNT_W = 3;
    localparam logic [2:0] IMP_RST_LAST = 3'(IMP_RST_CYCLES - 1);
    // single message vector used for every interrupt
    localparam int MSI_VEC_W = 5;
    localparam logic [4:0] MSI_VECTOR = 5'h00;

    typedef struct packed {
        logic msi_enable;
        logic intx_disable;
    } irq_cfg_t;

    typedef struct packed {
        logic msi;
        logic legacy;
        logic error;
    } irq_mode_t;

    typedef enum logic [1:0] {
        IMP_RESET = 2'b00,
        IMP_WAIT = 2'b01,
        IMP_DONE = 2'b11
    } imp_state_t;
endpackage

/* hdl/module_status_register.sv */
// What this block does
// - Bits 19 to 16 hold one loss-of-calibration flag per unit A to D, set on detected loss.
// - Each loss flag resets to zero, stays set until software writes one, and ignores zero.
// - Bit 12 reads zero during impedance calibration and one once it has finished.
// - The impedance controller is reset first and I/O counts as usable only after done.
// - Bit 8 shows one when the management controller reports a rear card with zone 3 on.
// - Bits 7 to 4 show per unit whether the input deserializer has finished calibrating.
// - Bit 3 reads one when the host set up message-signalled interrupts, else zero.
// - With message-signalled interrupts every interrupt goes out on one single vector.
// - Bit 2 reads one when legacy INTA signalling is in use, else zero.
// - Bit 0 reads one for an unsupported interrupt setup and zero for INTA or MSI.
// - While the setup error shows, no interrupt is generated at all.
`timescale 1ns/100ps
module module_status_register #(
    parameter int UNITS = modstat_pkg::UNIT_COUNT,
    parameter int ADDR_W = modstat_pkg::ADDR_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register access from the base address space
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic reg_hit,
    output logic reg_rvalid,
    output logic [31:0] reg_rdata,
    // input deserializer units
    input wire logic [UNITS-1:0] desr_cal_done,
    input wire logic [UNITS-1:0] desr_loss_event,
    // io impedance controller
    input wire logic imp_ctrl_locked,
    output logic imp_ctrl_rst,
    output logic io_impedance_cal_done,
    // management controller report
    input wire logic mgmt_rear_present,
    // host interrupt setup and request
    input wire modstat_pkg::irq_cfg_t irq_cfg,
    input wire logic irq_pending,
    output logic msi_req,
    output logic [modstat_pkg::MSI_VEC_W-1:0] msi_vector,
    output logic legacy_irq_assert,
    output logic [UNITS-1:0] calib_loss_flags
);
    // the status word layout is fixed at four units
    if (UNITS != 4) begin : g_bad_units
        $error("module_status_register: UNITS must be 4");
    end
    if (ADDR_W < 3) begin : g_bad_addr
        $error("module_status_register: ADDR_W too small");
    end
    // sizes that the package fixes and the logic relies on
    if (modstat_pkg::IMP_RST_CYCLES < 1) begin : g_bad_imp_len
        $error("module_status_register: impedance reset needs a cycle");
    end
    if (modstat_pkg::IMP_RST_CYCLES > (1 << modstat_pkg::IMP_CNT_W)) begin : g_bad_imp_cnt
        $error("module_status_register: impedance counter too narrow");
    end
    if (modstat_pkg::LOSS_LSB / 8 != modstat_pkg::LOSS_BYTE) begin : g_bad_lane
        $error("module_status_register: loss field outside its byte lane");
    end
    if ((modstat_pkg::LOSS_LSB % 8) + UNITS > 8) begin : g_bad_span
        $error("module_status_register: loss field spans two byte lanes");
    end
    if ($bits(modstat_pkg::MSI_VECTOR) != modstat_pkg::MSI_VEC_W) begin : g_bad_vec
        $error("module_status_register: vector width mismatch");
    end

    function automatic logic hits_status(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] ofs;
        ofs = ADDR_W'(modstat_pkg::MODULE_STATUS_OFS);
        hits_status = (addr == ofs);
    endfunction

    // impedance calibration sequencer
    modstat_pkg::imp_state_t imp_state_reg;
    modstat_pkg::imp_state_t imp_state_next;
    logic [modstat_pkg::IMP_CNT_W-1:0] imp_cnt_reg;
    logic [modstat_pkg::IMP_CNT_W-1:0] imp_cnt_next;
    logic imp_rst_reg;
    logic imp_rst_next;
    logic imp_done_reg;
    logic imp_done_next;

    always_comb begin
        imp_state_next = imp_state_reg;
        imp_cnt_next = imp_cnt_reg;
        imp_rst_next = 1'b0;
        imp_done_next = 1'b0;
        case (imp_state_reg)
            modstat_pkg::IMP_RESET: begin
                // hold the controller in reset long enough to restart it
                imp_rst_next = 1'b1;
                if (imp_cnt_reg == modstat_pkg::IMP_RST_LAST) begin
                    imp_cnt_next = '0;
                    imp_rst_next = 1'b0;
                    imp_state_next = modstat_pkg::IMP_WAIT;
                end else begin
                    imp_cnt_next = imp_cnt_reg + 1'b1;
                end
            end
            modstat_pkg::IMP_WAIT: begin
                if (imp_ctrl_locked) begin
                    imp_done_next = 1'b1;
                    imp_state_next = modstat_pkg::IMP_DONE;
                end
            end
            modstat_pkg::IMP_DONE: begin
                // a lost lock means the pads are untrusted again: recalibrate
                if (!imp_ctrl_locked) begin
                    imp_rst_next = 1'b1;
                    imp_state_next = modstat_pkg::IMP_RESET;
                end else begin
                    imp_done_next = 1'b1;
                end
            end
            default: begin
                imp_cnt_next = '0;
                imp_state_next = modstat_pkg::IMP_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            imp_state_reg <= modstat_pkg::IMP_RESET;
            imp_cnt_reg <= '0;
            imp_rst_reg <= 1'b1;
            imp_done_reg <= 1'b0;
        end else begin
            imp_state_reg <= imp_state_next;
            imp_cnt_reg <= imp_cnt_next;
            imp_rst_reg <= imp_rst_next;
            imp_done_reg <= imp_done_next;
        end
    end

    assign imp_ctrl_rst = imp_rst_reg;
    assign io_impedance_cal_done = imp_done_reg;

    // deserializer calibration state and loss detection
    logic [UNITS-1:0] cal_done_reg;
    logic [UNITS-1:0] cal_done_next;
    logic [UNITS-1:0] loss_set;

    always_comb begin
        cal_done_next = desr_cal_done;
        // a unit that was calibrated and drops out has lost calibration
        loss_set = desr_loss_event | (cal_done_reg & ~desr_cal_done);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cal_done_reg <= '0;
        end else begin
            cal_done_reg <= cal_done_next;
        end
    end

    // rear card report, registered so it lines up with the other status bits
    logic rear_zone_present_reg;
    logic rear_zone_next;
    logic rear_zone_present;

    always_comb begin
        rear_zone_next = mgmt_rear_present;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rear_zone_present_reg <= 1'b0;
        end else begin
            rear_zone_present_reg <= rear_zone_next;
        end
    end

    assign rear_zone_present = rear_zone_present_reg;

    // write-one-to-clear path for the loss flags
    logic [UNITS-1:0] loss_clr;

    always_comb begin
        loss_clr = '0;
        // only byte lane two carries the flags; other bits are dropped
        if (reg_wr && hits_status(reg_addr) && reg_be[modstat_pkg::LOSS_BYTE]) begin
            loss_clr = reg_wdata[modstat_pkg::LOSS_LSB +: UNITS];
        end
    end

    calib_loss_flag #(
        .UNITS(UNITS)
    ) u_loss (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .loss_set(loss_set),
        .loss_clr(loss_clr),
        .calib_loss_flags(calib_loss_flags)
    );

    // interrupt mechanism decode
    modstat_pkg::irq_mode_t irq_mode;

    irq_mode_decode u_mode (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .irq_cfg(irq_cfg),
        .irq_mode(irq_mode)
    );

    // interrupt delivery
    logic irq_live;
    logic irq_live_reg;
    logic msi_req_reg;
    logic msi_req_next;
    logic legacy_reg;
    logic legacy_next;
    logic [modstat_pkg::MSI_VEC_W-1:0] msi_vec_reg;
    logic [modstat_pkg::MSI_VEC_W-1:0] msi_vec_next;
    logic msi_mode_reg;

    always_comb begin
        // a bad setup silences everything, pending or not
        irq_live = irq_pending && !irq_mode.error;
        // one message per new request; level requests do not repeat it
        // a request already live when messages get enabled still gets its message
        msi_req_next = irq_live && irq_mode.msi && (!irq_live_reg || !msi_mode_reg);
        legacy_next = irq_live && irq_mode.legacy;
        msi_vec_next = modstat_pkg::MSI_VECTOR;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_live_reg <= 1'b0;
            msi_mode_reg <= 1'b0;
            msi_req_reg <= 1'b0;
            legacy_reg <= 1'b0;
            msi_vec_reg <= '0;
        end else begin
            irq_live_reg <= irq_live;
            msi_mode_reg <= irq_mode.msi;
            msi_req_reg <= msi_req_next;
            legacy_reg <= legacy_next;
            msi_vec_reg <= msi_vec_next;
        end
    end

    assign msi_req = msi_req_reg;
    assign msi_vector = msi_vec_reg;
    assign legacy_irq_assert = legacy_reg;

    // status word assembly and read port
    function automatic logic [31:0] status_word(
        input logic [UNITS-1:0] loss,
        input logic imp_done,
        input logic rear,
        input logic [UNITS-1:0] cal,
        input modstat_pkg::irq_mode_t mode
    );
        logic [31:0] w;
        w = modstat_pkg::MODULE_STATUS_RST;
        w[modstat_pkg::LOSS_LSB +: UNITS] = loss;
        w[modstat_pkg::IMP_DONE_BIT] = imp_done;
        w[modstat_pkg::REAR_BIT] = rear;
        w[modstat_pkg::CAL_DONE_LSB +: UNITS] = cal;
        w[modstat_pkg::MSI_BIT] = mode.msi;
        w[modstat_pkg::LEGACY_BIT] = mode.legacy;
        w[modstat_pkg::ERR_BIT] = mode.error;
        status_word = w;
    endfunction

    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    always_comb begin
        rvalid_next = reg_rd && hits_status(reg_addr);
        // zero between answers so a stale word never looks like a fresh one
        rdata_next = '0;
        if (rvalid_next) begin
            rdata_next = status_word(calib_loss_flags, imp_done_reg, rear_zone_present,
                                     cal_done_reg, irq_mode);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // combinational so the bus side can decode before the edge
    assign reg_hit = hits_status(reg_addr);
    assign reg_rvalid = rvalid_reg;
    assign reg_rdata = rdata_reg;
endmodule

/* verif/module_status_register_monitor.sv */
`timescale 1ns/100ps
module module_status_register_monitor #(
    parameter int UNITS = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic reg_hit,
    input wire logic [3:0] reg_be,
    input wire logic reg_rvalid,
    input wire logic [31:0] reg_rdata,
    // status sources
    input wire logic [UNITS-1:0] desr_loss_event,
    input wire logic [UNITS-1:0] calib_loss_flags,
    input wire logic imp_ctrl_locked,
    input wire logic imp_ctrl_rst,
    input wire logic io_impedance_cal_done,
    // interrupts
    input wire modstat_pkg::irq_cfg_t irq_cfg,
    input wire logic irq_pending,
    input wire logic msi_req,
    input wire logic [4:0] msi_vector,
    input wire logic legacy_irq_assert
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic w1c;
    assign w1c = reg_wr && reg_hit && reg_be[2];
    read_answer_a: assert property (reg_rvalid == $past(reg_rd && reg_hit))
        else $error("read answer wrong");
    reserved_zero_a: assert property ((reg_rdata & 32'hFFF0_EE02) == 32'h0)
        else $error("reserved bit set");
    loss_word_a: assert property (reg_rvalid |-> reg_rdata[19:16] == $past(calib_loss_flags))
        else $error("loss field wrong");
    loss_set_a: assert property (|desr_loss_event |=>
        (calib_loss_flags & $past(desr_loss_event)) == $past(desr_loss_event))
        else $error("loss flag not set");
    loss_sticky_a: assert property (!w1c |=>
        (calib_loss_flags & $past(calib_loss_flags)) == $past(calib_loss_flags))
        else $error("loss flag dropped");
    imp_ready_a: assert property (io_impedance_cal_done |-> !imp_ctrl_rst)
        else $error("done during reset");
    imp_lock_a: assert property ($rose(io_impedance_cal_done) |-> $past(imp_ctrl_locked))
        else $error("done without lock");
    one_vector_a: assert property (msi_vector == 5'h00)
        else $error("vector not zero");
    msi_gate_a: assert property (msi_req |->
        $past(irq_pending) && $past(irq_cfg.msi_enable, 2) ##1 !msi_req)
        else $error("bad message request");
    legacy_gate_a: assert property (legacy_irq_assert |->
        !$past(irq_cfg.intx_disable, 2) && !$past(irq_cfg.msi_enable, 2))
        else $error("bad legacy assert");
    cover property (reg_rvalid && reg_rdata[19:16] != 4'h0);
    cover property (msi_req);
    cover property (legacy_irq_assert);
endmodule

bind module_status_register module_status_register_monitor #(.UNITS(UNITS)) mon_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_hit(reg_hit), .reg_be(reg_be), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .desr_loss_event(desr_loss_event), .calib_loss_flags(calib_loss_flags),
    .imp_ctrl_locked(imp_ctrl_locked), .imp_ctrl_rst(imp_ctrl_rst),
    .io_impedance_cal_done(io_impedance_cal_done), .irq_cfg(irq_cfg),
    .irq_pending(irq_pending), .msi_req(msi_req), .msi_vector(msi_vector),
    .legacy_irq_assert(legacy_irq_assert)
);

/* verif/module_status_register_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module module_status_register_tb;
    localparam logic [8:0] OFS = modstat_pkg::MODULE_STATUS_OFS;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, imp_ctrl_locked = 1'b0;
    logic mgmt_rear_present = 1'b0, irq_pending = 1'b0;
    logic [3:0] reg_be = 4'h0, desr_cal_done = 4'h0, desr_loss_event = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, got;
    modstat_pkg::irq_cfg_t irq_cfg = 2'b00;
    logic reg_hit, reg_rvalid, imp_ctrl_rst, io_impedance_cal_done, msi_req;
    logic legacy_irq_assert, vld;
    logic [4:0] msi_vector;
    logic [3:0] calib_loss_flags;
    int num_errors = 0, check_count = 0;
    always #20 core_clk = ~core_clk;
    module_status_register dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_hit(reg_hit),
        .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .desr_cal_done(desr_cal_done),
        .desr_loss_event(desr_loss_event), .imp_ctrl_locked(imp_ctrl_locked),
        .imp_ctrl_rst(imp_ctrl_rst), .io_impedance_cal_done(io_impedance_cal_done),
        .mgmt_rear_present(mgmt_rear_present), .irq_cfg(irq_cfg), .irq_pending(irq_pending),
        .msi_req(msi_req), .msi_vector(msi_vector), .legacy_irq_assert(legacy_irq_assert),
        .calib_loss_flags(calib_loss_flags)
    );
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [8:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        vld = reg_rvalid;
        got = reg_rdata;
    endtask
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= OFS;
        reg_be <= be;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // expected word from what the bench itself drives
    function automatic logic [31:0] word(input logic [3:0] l, input logic d);
        return {12'h000, l, 3'h0, d, 3'h0, mgmt_rear_present, desr_cal_done,
            irq_cfg.msi_enable, !irq_cfg.msi_enable && !irq_cfg.intx_disable, 1'b0,
            !irq_cfg.msi_enable && irq_cfg.intx_disable};
    endfunction
    task automatic wait_done();
        int n;
        for (n = 0; n < 50 && io_impedance_cal_done !== 1'b1; n++)
            tick(1);
        if (n == 50) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic check_impedance();
        int n;
        n = 0;
        `CHK(imp_ctrl_rst, 1'b1)
        `CHK(io_impedance_cal_done, 1'b0)
        `CHK(calib_loss_flags, 4'h0)
        @(posedge core_clk);
        sys_rst <= 1'b0;
        tick(1);
        while (imp_ctrl_rst === 1'b1 && n < 20) begin
            n++;
            tick(1);
        end
        if (n == 20) begin
            num_errors++;
            give_verdict();
        end
        `CHK(n + 1, modstat_pkg::IMP_RST_CYCLES)
        rd(OFS);
        `CHK(got, word(4'h0, 1'b0))
        `CHK(vld, 1'b1)
        `CHK(reg_hit, 1'b1)
        @(posedge core_clk);
        imp_ctrl_locked <= 1'b1;
        wait_done();
        `CHK(imp_ctrl_rst, 1'b0)
        // lost lock must restart the controller
        @(posedge core_clk);
        imp_ctrl_locked <= 1'b0;
        tick(2);
        `CHK(io_impedance_cal_done, 1'b0)
        `CHK(imp_ctrl_rst, 1'b1)
        @(posedge core_clk);
        imp_ctrl_locked <= 1'b1;
        wait_done();
        rd(OFS);
        `CHK(got, word(4'h0, 1'b1))
    endtask
    task automatic check_loss();
        @(posedge core_clk);
        desr_cal_done <= 4'hF;
        mgmt_rear_present <= 1'b1;
        desr_loss_event <= 4'h2;
        @(posedge core_clk);
        desr_loss_event <= 4'h0;
        #1;
        `CHK(calib_loss_flags, 4'h2)
        wr(4'hB, 32'h000F_0000);
        `CHK(calib_loss_flags, 4'h2)
        wr(4'h4, 32'h0000_0000);
        `CHK(calib_loss_flags, 4'h2)
        @(posedge core_clk);
        desr_cal_done <= 4'h7;
        tick(2);
        `CHK(calib_loss_flags, 4'hA)
        rd(OFS);
        `CHK(got, word(4'hA, 1'b1))
        wr(4'h4, 32'h0002_0000);
        `CHK(calib_loss_flags, 4'h8)
        wr(4'hF, 32'hFFFF_FFFF);
        rd(OFS);
        `CHK(got, word(4'h0, 1'b1))
        rd(9'h008);
        `CHK(vld, 1'b0)
        `CHK(reg_hit, 1'b0)
    endtask
    task automatic check_irq();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            irq_cfg <= 2'(i);
            tick(3);
            rd(OFS);
            `CHK(got, word(4'h0, 1'b1))
            @(posedge core_clk);
            irq_pending <= 1'b1;
            tick(1);
            `CHK(msi_req, irq_cfg.msi_enable)
            `CHK(legacy_irq_assert, !irq_cfg.msi_enable && !irq_cfg.intx_disable)
            `CHK(msi_vector, 5'h00)
            tick(1);
            `CHK(msi_req, 1'b0)
            `CHK(legacy_irq_assert, !irq_cfg.msi_enable && !irq_cfg.intx_disable)
            @(posedge core_clk);
            irq_pending <= 1'b0;
            tick(3);
        end
    endtask
    initial begin
        repeat (15) @(posedge core_clk);
        check_impedance();
        check_loss();
        check_irq();
        give_verdict();
    end
endmodule
